// ### design/pcu_position_compare.v
// Purpose: Position compare unit with APB registers, interrupt and target pin select
// Assumes: Position inputs come from logic on clk_sys
// Notes: APB slave answers with zero wait states; unmapped reads return zero
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "pcu_regs.vh"
module pcu_position_compare #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Positions
  input wire [WIDTH-1:0] internalActualPosition,
  input wire [WIDTH-1:0] encoderPosition,
  input wire [WIDTH-1:0] homePosition,
  input wire [WIDTH-1:0] internalLatchValue,
  input wire [WIDTH-1:0] encoderLatchValue,
  input wire [WIDTH-1:0] revolutionCounter,
  // Other target pin flags
  input wire targetReachedFlag,
  input wire velocityReachedFlag,
  input wire encoderFailFlag,
  // Outputs
  output reg targetReachedPin,
  output reg interrupt,
  output wire matchFlag
);
  reg [31:0] referenceConfiguration;
  reg [31:0] compareValue;
  reg [1:0] events;
  reg [1:0] mask;
  wire matchPulse;
  wire crossPulse;
  wire wrEn;
  wire rdEn;
  wire [9:0] wordIdx;
  wire [1:0] tpinSel;

  function [9:0] byteToIdx;
    input [11:0] a;
    begin
      byteToIdx = a[11:2];
    end
  endfunction

  assign wordIdx = byteToIdx(paddr);
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign tpinSel = referenceConfiguration[`PCU_BIT_TPIN_HI:`PCU_BIT_TPIN_LO];

  pcu_compare_core #(
    .WIDTH(WIDTH)
  ) u_core (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .source(referenceConfiguration[`PCU_BIT_SOURCE]),
    .pairSel(referenceConfiguration[`PCU_BIT_PAIR_HI:`PCU_BIT_PAIR_LO]),
    .internalActualPosition(internalActualPosition),
    .encoderPosition(encoderPosition),
    .compareValue(compareValue[WIDTH-1:0]),
    .homePosition(homePosition),
    .internalLatchValue(internalLatchValue),
    .encoderLatchValue(encoderLatchValue),
    .revolutionCounter(revolutionCounter),
    .matchFlag(matchFlag),
    .matchPulse(matchPulse),
    .crossPulse(crossPulse)
  );

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      referenceConfiguration <= `PCU_RST_REFCONF;
      compareValue <= `PCU_RST_COMPVAL;
      mask <= 2'h0;
      events <= 2'h0;
    end else begin
      if (wrEn && wordIdx == {2'h0, `PCU_IDX_REFCONF})
        referenceConfiguration <= pwdata;
      if (wrEn && wordIdx == {2'h0, `PCU_IDX_COMPVAL})
        compareValue <= pwdata;
      if (wrEn && wordIdx == {2'h0, `PCU_IDX_MASK})
        mask <= pwdata[1:0];
      // Set wins over write-one-to-clear; a traverse also records the match event
      events <= (events & ~((wrEn && wordIdx == {2'h0, `PCU_IDX_EVENTS}) ?
                 pwdata[1:0] : 2'h0)) | {crossPulse, matchPulse | crossPulse};
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      interrupt <= 1'b0;
      targetReachedPin <= 1'b0;
    end else begin
      if (rdEn) begin
        case (wordIdx)
          {2'h0, `PCU_IDX_REFCONF}: prdata <= referenceConfiguration;
          {2'h0, `PCU_IDX_COMPVAL}: prdata <= compareValue;
          {2'h0, `PCU_IDX_STATUS}: prdata <= {31'h00000000, matchFlag};
          {2'h0, `PCU_IDX_EVENTS}: prdata <= {30'h00000000, events};
          {2'h0, `PCU_IDX_MASK}: prdata <= {30'h00000000, mask};
          default: prdata <= 32'h00000000;
        endcase
      end
      interrupt <= |(events & mask);
      case (tpinSel)
        2'h0: targetReachedPin <= targetReachedFlag;
        2'h1: targetReachedPin <= velocityReachedFlag;
        2'h2: targetReachedPin <= encoderFailFlag;
        2'h3: targetReachedPin <= matchFlag;
        default: targetReachedPin <= targetReachedFlag;
      endcase
    end
  end
endmodule // pcu_position_compare

// ### design/pcu_regs.vh
// Purpose: Register map, field positions and reset values of the position compare unit
// Assumes: APB with 32-bit data; byte addresses are printed indices times four
// Notes: Offsets are word indices; events bit 0 is the match event, bit 1 marks a traverse
// Function
// - Comparison runs continuously, driving one match flag and one match event.
// - Source select 0 compares the internal actual position.
// - Source select 1 compares the encoder position instead.
// - Exact equality of operand and reference sets flag and raises event.
// - Compare value is in microstep units for encoder comparison.
// - Encoder stepping past compare value records event without setting flag.
// - Pair select 00 compares with compare value; 01 with home position.
// - Pair select 10 compares position with matching latch value.
// - Pair select 11 compares revolution counter against compare value.
// - Only the selected operand and reference pair may produce flag or event.
// - Match result drives interrupt output or target-reached pin.
// - Target pin source 11 puts match flag on target-reached pin.
`ifndef PCU_REGS_VH
`define PCU_REGS_VH
`define PCU_IDX_REFCONF 8'h01
`define PCU_IDX_COMPVAL 8'h32
`define PCU_IDX_STATUS 8'h40
`define PCU_IDX_EVENTS 8'h41
`define PCU_IDX_MASK 8'h42
`define PCU_BIT_SOURCE 0
`define PCU_BIT_PAIR_LO 1
`define PCU_BIT_PAIR_HI 2
`define PCU_BIT_TPIN_LO 3
`define PCU_BIT_TPIN_HI 4
`define PCU_RST_REFCONF 32'h00000000
`define PCU_RST_COMPVAL 32'h00000000
`define PCU_RST_MASK 32'h00000000
`define PCU_EVT_MATCH 0
`define PCU_EVT_CROSS 1
`endif

// ### design/pcu_compare_core.v
// Purpose: Selects the compare pair and tests equality and crossing each cycle
// Assumes: Operands are signed and sampled on clk_sys
// Notes: Result is registered one cycle after the operands
`timescale 1ns/100ps
module pcu_compare_core #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Selects
  input wire source,
  input wire [1:0] pairSel,
  // Operands
  input wire [WIDTH-1:0] internalActualPosition,
  input wire [WIDTH-1:0] encoderPosition,
  input wire [WIDTH-1:0] compareValue,
  input wire [WIDTH-1:0] homePosition,
  input wire [WIDTH-1:0] internalLatchValue,
  input wire [WIDTH-1:0] encoderLatchValue,
  input wire [WIDTH-1:0] revolutionCounter,
  // Results
  output reg matchFlag,
  output reg matchPulse,
  output reg crossPulse
);
  reg [WIDTH-1:0] operand;
  reg [WIDTH-1:0] reference;
  reg [1:0] prevDiffSign;
  reg prevValid;
  reg [1:0] prevPair;
  reg prevSource;
  wire equal;
  wire signNow;
  wire [WIDTH-1:0] diff;

  always @* begin
    operand = source ? encoderPosition : internalActualPosition;
    reference = compareValue;
    case (pairSel)
      2'h0: reference = compareValue;
      2'h1: reference = homePosition;
      2'h2: reference = source ? encoderLatchValue : internalLatchValue;
      2'h3: begin
        operand = revolutionCounter;
        reference = compareValue;
      end
      default: reference = compareValue;
    endcase
  end

  assign equal = (operand == reference);
  assign diff = operand - reference;
  assign signNow = diff[WIDTH-1];

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      matchFlag <= 1'b0;
      matchPulse <= 1'b0;
      crossPulse <= 1'b0;
      prevDiffSign <= 2'h0;
      prevValid <= 1'b0;
      prevPair <= 2'h0;
      prevSource <= 1'b0;
    end else begin
      matchFlag <= equal;
      matchPulse <= equal & ~matchFlag;
      // Crossing only counts when the pair did not change between samples
      crossPulse <= source & (pairSel != 2'h3) & prevValid & ~equal &
                    (prevPair == pairSel) & (prevSource == source) &
                    (prevDiffSign[0] != signNow) & (prevDiffSign[1] == 1'b0);
      prevDiffSign <= {equal, signNow};
      prevValid <= 1'b1;
      prevPair <= pairSel;
      prevSource <= source;
    end
  end
endmodule // pcu_compare_core

// ### tb/pcu_monitor.sv
// Purpose: Port assertions for the position compare unit
// Assumes: Configuration is tracked from APB writes at the access edge
// Notes: Every check except a_match_irq is guarded by one cycle out of reset
`timescale 1ns/100ps
module pcu_monitor #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Positions and flags
  input wire [WIDTH-1:0] internalActualPosition,
  input wire [WIDTH-1:0] encoderPosition,
  input wire [WIDTH-1:0] homePosition,
  input wire [WIDTH-1:0] internalLatchValue,
  input wire [WIDTH-1:0] encoderLatchValue,
  input wire [WIDTH-1:0] revolutionCounter,
  input wire targetReachedFlag,
  input wire velocityReachedFlag,
  input wire encoderFailFlag,
  // Outputs
  input wire targetReachedPin,
  input wire interrupt,
  input wire matchFlag
);
  reg [31:0] cfg, cmp, msk;
  wire [WIDTH-1:0] op = cfg[0] ? encoderPosition : internalActualPosition;
  wire [WIDTH-1:0] lat = cfg[0] ? encoderLatchValue : internalLatchValue;
  wire e0 = op == cmp;
  wire e1 = op == homePosition;
  wire e2 = op == lat;
  wire e3 = revolutionCounter == cmp;
  wire [1:0] ts = cfg[4:3];
  wire pe = ts == 0 ? targetReachedFlag : ts == 1 ? velocityReachedFlag :
    ts == 2 ? encoderFailFlag : matchFlag;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= 32'h0;
      cmp <= 32'h0;
      msk <= 32'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == 12'h004) cfg <= pwdata;
      if (paddr == 12'h0C8) cmp <= pwdata;
      if (paddr == 12'h108) msk <= pwdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_pair_value: assert property ($past(reset_n) && $past(cfg[2:1]) == 2'd0 |->
    matchFlag == $past(e0)) else $error("match wrong against compare value");
  a_pair_home: assert property ($past(reset_n) && $past(cfg[2:1]) == 2'd1 |->
    matchFlag == $past(e1)) else $error("match wrong against home position");
  a_pair_latch: assert property ($past(reset_n) && $past(cfg[2:1]) == 2'd2 |->
    matchFlag == $past(e2)) else $error("match wrong against latch value");
  a_pair_rev: assert property ($past(reset_n) && $past(cfg[2:1]) == 2'd3 |->
    matchFlag == $past(e3)) else $error("match wrong for revolution counter");
  a_match_irq: assert property ($rose(matchFlag) ##1 msk[0] |=> interrupt)
    else $error("unmasked match gave no interrupt");
  a_mask_quiet: assert property ($past(reset_n) && $past(msk) == 32'h0 |-> !interrupt)
    else $error("interrupt with all sources masked");
  a_pin_select: assert property ($past(reset_n) |-> targetReachedPin == $past(pe))
    else $error("target pin shows wrong flag");
  a_pin_match: assert property ($past(reset_n) && $past(cfg[4:3]) == 2'd3 |->
    targetReachedPin == $past(matchFlag)) else $error("target pin does not follow match flag");
endmodule // pcu_monitor
bind pcu_position_compare pcu_monitor #(.WIDTH(WIDTH)) pcu_monitor_inst (.*);

// ### tb/testbench.sv
// Purpose: Self-checking bench for the position compare unit
// Assumes: Zero wait APB slave, byte address is index times four
// Notes: Bench keeps its own copies of operands and reference
`timescale 1ns/100ps
module testbench;
  reg clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd, cmp, rf, pos [0:5];
  reg [2:0] flg = 3'h0;
  wire pready, pslverr, tpin, irq, mflag;
  wire [31:0] prdata;
  integer errCount = 0, numChecks = 0, k, t, op;
  pcu_position_compare pcu_position_compare_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .internalActualPosition(pos[0]),
    .encoderPosition(pos[1]), .homePosition(pos[2]), .internalLatchValue(pos[3]),
    .encoderLatchValue(pos[4]), .revolutionCounter(pos[5]), .targetReachedFlag(flg[0]),
    .velocityReachedFlag(flg[1]), .encoderFailFlag(flg[2]), .targetReachedPin(tpin),
    .interrupt(irq), .matchFlag(mflag));
  always #5 clk_sys = ~clk_sys;
  task chk(input [31:0] g, input [31:0] e);
    begin
      numChecks = numChecks + 1;
      if (g !== e) begin
        errCount = errCount + 1;
        $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // Reference model of the compare selection grid
  function expMatch(input integer cfgWord, input [31:0] cmpVal);
    reg [31:0] a;
    reg [31:0] b;
    begin
      a = cfgWord[0] ? pos[1] : pos[0];
      case (cfgWord[2:1])
        2'h0: b = cmpVal;
        2'h1: b = pos[2];
        2'h2: b = cfgWord[0] ? pos[4] : pos[3];
        default: begin
          a = pos[5];
          b = cmpVal;
        end
      endcase
      expMatch = (a == b);
    end
  endfunction
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      chk(pslverr, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdchk(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  initial begin
    #100000;
    errCount = errCount + 1;
    end_sim;
  end
  initial begin
    k = $urandom(89910);
    for (k = 0; k < 6; k = k + 1) pos[k] = 32'h0;
    cyc(20);
    reset_n <= 1'b1;
    rdchk(12'h004, 32'h0);
    rdchk(12'h0C8, 32'h0);
    rdchk(12'h108, 32'h0);
    apb(1'b1, 12'h3FC, 32'hFFFFFFFF);
    rdchk(12'h3FC, 32'h0);
    $display("register reset test done");
    for (k = 0; k < 8; k = k + 1) begin
      cmp = $urandom;
      apb(1'b1, 12'h0C8, cmp);
      apb(1'b1, 12'h004, {27'h0, 2'b11, k[2:0]});
      for (t = 0; t < 6; t = t + 1) pos[t] <= $urandom;
      op = k > 5 ? 5 : k % 2;
      @(posedge clk_sys);
      rf = (k < 2 || k > 5) ? cmp : k < 4 ? pos[2] : pos[3 + k % 2];
      pos[op] <= rf;
      cyc(3);
      chk(mflag, expMatch(k, cmp));
      chk(tpin, expMatch(k, cmp));
      // Break the selected pair and make an unselected pair equal
      pos[op] <= rf + 32'h1;
      if (op == 5) begin
        pos[0] <= cmp;
        pos[1] <= cmp;
      end else begin
        pos[5] <= cmp;
      end
      cyc(2);
      chk(mflag, expMatch(k, cmp));
    end
    $display("compare grid test done");
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h0C8, 32'h100);
    pos[1] <= 32'hFF;
    cyc(2);
    apb(1'b1, 12'h104, 32'h3);
    pos[1] <= 32'h101;
    cyc(2);
    chk(mflag, 32'h0);
    rdchk(12'h104, 32'h3);
    $display("traverse test done");
    apb(1'b1, 12'h108, 32'h1);
    apb(1'b1, 12'h104, 32'h3);
    cyc(2);
    chk(irq, 32'h0);
    pos[1] <= 32'h100;
    cyc(4);
    chk(irq, 32'h1);
    rdchk(12'h104, 32'h1);
    rdchk(12'h100, 32'h1);
    apb(1'b1, 12'h108, 32'h0);
    cyc(2);
    chk(irq, 32'h0);
    apb(1'b1, 12'h108, 32'h1);
    apb(1'b1, 12'h104, 32'h3);
    cyc(2);
    chk(irq, 32'h0);
    $display("interrupt test done");
    for (t = 0; t < 3; t = t + 1) begin
      apb(1'b1, 12'h004, {t[1:0], 3'b001});
      flg <= $urandom;
      cyc(3);
      chk(tpin, flg[t]);
    end
    rdchk(12'h004, 32'h11);
    $display("target pin test done");
    end_sim;
  end
endmodule // testbench
